// ===== design/srasl_pkg.sv
package srasl_pkg;
  // device register indexes
  localparam logic [4:0] REG_EE_CTRL = 5'h1c;
  localparam logic [4:0] REG_DIAG = 5'h1e;
  localparam logic [4:0] REG_PART_ID = 5'h0f;
  localparam int ADDR_TOP_POS = 6;
  localparam int WORD_W = 16;
  localparam int STORE_W = 10;
  localparam int FLAG_W = 6;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  // controller register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_TXWORD = 8'h04;
  localparam logic [7:0] OFS_RXWORD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  // command register fields
  localparam int CMD_ADDR_POS = 0;
  localparam int CMD_RW_POS = 5;
  // status and interrupt bit positions
  localparam int ST_BUSY_POS = 0;
  localparam int ST_NACK_POS = 1;
  localparam int IRQ_DONE_POS = 0;
  localparam int IRQ_NACK_POS = 1;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;
  // link timing
  localparam int CLK_HZ = 40_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QTR_CYCLES = CLK_HZ / (4 * SCL_HZ);
endpackage

// ===== design/srasl_if.sv
interface srasl_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // open-drain lines with pull-up
  assign scl = (scl_m_oe && !scl_m_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o)) ? 1'b0 : 1'b1;
  modport target (
    input scl,
    input sda,
    output sda_d_o,
    output sda_d_oe
  );
  modport ctrl (
    input scl,
    input sda,
    output scl_m_o,
    output scl_m_oe,
    output sda_m_o,
    output sda_m_oe
  );
endinterface

// ===== design/srasl_sync.sv
module srasl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== design/srasl_target.sv
module srasl_target (
  input wire logic clk,
  input wire logic rst_b,
  srasl_if.target bus,
  input wire logic logic_rail_pin,
  input wire logic locked_mode,
  input wire logic [5:0] crit_flags,
  input wire logic thermal_warning_flag,
  input wire logic overtemp_flag,
  input wire logic sync_loss_flag,
  input wire logic gate_driver_fault_flag,
  input wire logic hard_overcurrent_flag,
  input wire logic supply_overvoltage_flag,
  input wire logic supply_undervoltage_flag,
  input wire logic [9:0] write_cycle_count,
  output logic reg_wr_stb,
  output logic [4:0] reg_wr_addr,
  output logic [9:0] reg_wr_data
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SACK,
    ST_RX,
    ST_TX,
    ST_MACK,
    ST_WAIT
  } srasl_tgt_e;

  srasl_tgt_e state;
  logic scl_s;
  logic sda_s;
  logic rail_ok;
  logic scl_d;
  logic sda_d;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] hi;
  logic half;
  logic [4:0] ptr;
  logic rw;
  logic mack;
  logic [15:0] tx;
  logic sda_oe;
  logic [15:0] lfsr;
  logic [9:0] regs [32];

  srasl_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({bus.scl, bus.sda, logic_rail_pin}),
    .q({scl_s, sda_s, rail_ok})
  );

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_seen = scl_s && scl_d && sda_d && !sda_s;
  wire stop_seen = scl_s && scl_d && !sda_d && sda_s;
  wire byte_end = scl_fall && (cnt == 4'h8);
  wire addr_ok = (sh[7:srasl_pkg::ADDR_TOP_POS] == 2'b00);
  wire [6:0] diag_flags = {thermal_warning_flag, overtemp_flag, sync_loss_flag,
    gate_driver_fault_flag, hard_overcurrent_flag, supply_overvoltage_flag,
    supply_undervoltage_flag};
  wire is_ee = (ptr == srasl_pkg::REG_EE_CTRL);
  wire is_diag = (ptr == srasl_pkg::REG_DIAG);
  wire is_pid = (ptr == srasl_pkg::REG_PART_ID);
  wire scramble = locked_mode && !is_ee && !is_diag && !is_pid;
  wire [9:0] rd_low = is_ee ? write_cycle_count :
    is_diag ? {diag_flags, 3'h0} :
    scramble ? lfsr[9:0] : regs[ptr];
  wire [15:0] rd_word = {crit_flags, rd_low};
  wire [9:0] wr_low = {hi[1:0], sh};

  assign bus.sda_d_o = 1'b0;
  assign bus.sda_d_oe = sda_oe;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      lfsr <= srasl_pkg::LFSR_SEED;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ srasl_pkg::LFSR_TAPS) : (lfsr >> 1);
    end
  end

  // storage is written only on a complete word
  always_ff @(posedge clk) begin
    if (reg_wr_stb) begin
      regs[reg_wr_addr] <= reg_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      hi <= 8'h00;
      half <= 1'b0;
      ptr <= 5'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      tx <= 16'h0000;
      sda_oe <= 1'b0;
      reg_wr_stb <= 1'b0;
      reg_wr_addr <= 5'h00;
      reg_wr_data <= 10'h000;
    end else begin
      reg_wr_stb <= 1'b0;
      if (!rail_ok) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_seen) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        half <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE, ST_WAIT: begin
          end
          ST_ADDR: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_s};
              cnt <= cnt + 4'h1;
            end else if (byte_end) begin
              if (addr_ok) begin
                ptr <= sh[5:1];
                rw <= sh[0];
                sda_oe <= 1'b1;
                state <= ST_SACK;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_SACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rw) begin
                tx <= rd_word;
                sda_oe <= !rd_word[15];
                state <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_s};
              cnt <= cnt + 4'h1;
            end else if (byte_end) begin
              sda_oe <= 1'b1;
              state <= ST_SACK;
              if (!half) begin
                hi <= sh;
                half <= 1'b1;
              end else begin
                reg_wr_stb <= 1'b1;
                reg_wr_addr <= ptr;
                reg_wr_data <= wr_low;
                ptr <= ptr + 5'h01;
                half <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall) begin
              tx <= {tx[14:0], 1'b0};
              if (cnt == 4'h8) begin
                sda_oe <= 1'b0;
                mack <= 1'b0;
                state <= ST_MACK;
                half <= !half;
                if (half) begin
                  ptr <= ptr + 5'h01;
                end
              end else begin
                sda_oe <= !tx[14];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack <= !sda_s;
            end else if (scl_fall) begin
              cnt <= 4'h0;
              if (mack) begin
                state <= ST_TX;
                if (half) begin
                  sda_oe <= !tx[15];
                end else begin
                  tx <= rd_word;
                  sda_oe <= !rd_word[15];
                end
              end else begin
                state <= ST_WAIT;
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// ===== design/srasl_ctrl.sv
module srasl_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  srasl_if.ctrl bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  typedef enum logic [1:0] {
    M_IDLE,
    M_START,
    M_BITS,
    M_STOP
  } srasl_mst_e;

  localparam logic [7:0] QTR_LAST = 8'(srasl_pkg::QTR_CYCLES - 1);

  srasl_mst_e state;
  logic sda_s;
  logic [4:0] cmd_addr;
  logic cmd_rw;
  logic [15:0] txw;
  logic [15:0] rxw;
  logic busy;
  logic nack;
  logic [1:0] irq_stat;
  logic [1:0] irq_en;
  logic [7:0] qcnt;
  logic [1:0] q;
  logic [1:0] byte_i;
  logic [3:0] bit_i;
  logic scl_oe;
  logic sda_oe;
  logic ev_done;
  logic ev_nack;

  srasl_sync #(
    .W(1)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(bus.sda),
    .q(sda_s)
  );

  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe = scl_oe;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_oe;

  wire wr_acc = psel && penable && pready && pwrite;
  wire setup = psel && !penable;
  wire wr_cmd = wr_acc && (paddr == srasl_pkg::OFS_CMD);
  wire wr_tx = wr_acc && (paddr == srasl_pkg::OFS_TXWORD);
  wire wr_clr = wr_acc && (paddr == srasl_pkg::OFS_IRQ_CLR);
  wire wr_en = wr_acc && (paddr == srasl_pkg::OFS_IRQ_EN);
  wire [31:0] status_word = {30'h0, nack, busy};
  wire [31:0] rd_mux =
    (paddr == srasl_pkg::OFS_CMD) ? {26'h0, cmd_rw, cmd_addr} :
    (paddr == srasl_pkg::OFS_TXWORD) ? {16'h0, txw} :
    (paddr == srasl_pkg::OFS_RXWORD) ? {16'h0, rxw} :
    (paddr == srasl_pkg::OFS_STATUS) ? status_word :
    (paddr == srasl_pkg::OFS_IRQ_STAT) ? {30'h0, irq_stat} :
    (paddr == srasl_pkg::OFS_IRQ_EN) ? {30'h0, irq_en} : 32'h0;
  wire tick = busy && (qcnt == QTR_LAST);
  wire [7:0] cur_byte = (byte_i == 2'h0) ? {2'b00, cmd_addr, cmd_rw} :
    (byte_i == 2'h1) ? txw[15:8] : txw[7:0];
  wire drives_byte = (byte_i == 2'h0) || !cmd_rw;
  wire data_bit = (bit_i != 4'h8);
  wire drive_low = data_bit ? (drives_byte && !cur_byte[3'h7 - bit_i[2:0]]) :
    (!drives_byte && (byte_i == 2'h1));
  wire [1:0] ev_vec = {ev_nack, ev_done};
  wire [1:0] clr_vec = wr_clr ? pwdata[1:0] : 2'h0;

  // apb slave: one wait-free access phase, read data captured in setup
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      irq_stat <= 2'h0;
      irq_en <= srasl_pkg::IRQ_EN_RESET;
      irq <= 1'b0;
      txw <= 16'h0000;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= rd_mux;
      end
      if (wr_tx) begin
        txw <= pwdata[15:0];
      end
      if (wr_en) begin
        irq_en <= pwdata[1:0];
      end
      // a new event wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~clr_vec) | ev_vec;
      irq <= |(irq_stat & irq_en);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= M_IDLE;
      busy <= 1'b0;
      nack <= 1'b0;
      cmd_addr <= 5'h00;
      cmd_rw <= 1'b0;
      rxw <= 16'h0000;
      qcnt <= 8'h00;
      q <= 2'h0;
      byte_i <= 2'h0;
      bit_i <= 4'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      ev_done <= 1'b0;
      ev_nack <= 1'b0;
    end else begin
      ev_done <= 1'b0;
      ev_nack <= 1'b0;
      qcnt <= (tick || !busy) ? 8'h00 : qcnt + 8'h01;
      if (wr_cmd && !busy) begin
        cmd_addr <= pwdata[srasl_pkg::CMD_ADDR_POS +: 5];
        cmd_rw <= pwdata[srasl_pkg::CMD_RW_POS];
        busy <= 1'b1;
        nack <= 1'b0;
        state <= M_START;
      end else if (tick) begin
        q <= q + 2'h1;
        unique case (state)
          M_IDLE: begin
          end
          M_START: begin
            sda_oe <= 1'b1;
            q <= 2'h0;
            byte_i <= 2'h0;
            bit_i <= 4'h0;
            state <= M_BITS;
          end
          M_BITS: begin
            unique case (q)
              2'h0: scl_oe <= 1'b1;
              2'h1: sda_oe <= drive_low;
              2'h2: scl_oe <= 1'b0;
              2'h3: begin
                if (data_bit && !drives_byte) begin
                  rxw <= {rxw[14:0], sda_s};
                end
                if (!data_bit) begin
                  bit_i <= 4'h0;
                  byte_i <= byte_i + 2'h1;
                  if (drives_byte && sda_s) begin
                    nack <= 1'b1;
                    ev_nack <= 1'b1;
                    state <= M_STOP;
                  end else if (byte_i == 2'h2) begin
                    state <= M_STOP;
                  end
                end else begin
                  bit_i <= bit_i + 4'h1;
                end
              end
            endcase
          end
          M_STOP: begin
            unique case (q)
              2'h0: scl_oe <= 1'b1;
              2'h1: sda_oe <= 1'b1;
              2'h2: scl_oe <= 1'b0;
              2'h3: begin
                sda_oe <= 1'b0;
                busy <= 1'b0;
                ev_done <= 1'b1;
                state <= M_IDLE;
              end
            endcase
          end
        endcase
      end
    end
  end
endmodule

// ===== tb/srasl_checker.sv
module srasl_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_dev_edge_low: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("target changed data while clock high");
  a_dev_bit_hold: assert property ($rose(sda_d_oe) |-> ##[150:250] (scl && sda_d_oe))
    else $error("target drive not held into clock high");
  a_start_release: assert property (($fell(sda) && scl) |=> !sda_d_oe [*4])
    else $error("target drives after start");
  a_stop_quiet: assert property (($rose(sda) && scl) |=> !sda_d_oe [*8])
    else $error("target drives after stop");
  a_no_clash: assert property (!(sda_d_oe && sda_m_oe && scl))
    else $error("both ends drive data while clock high");
  a_data_stable: assert property (($changed(sda_m_oe) && scl) |-> $past(scl, 50))
    else $error("controller data moved during clock high");
  a_scl_high_len: assert property ($rose(scl) |-> ##190 scl)
    else $error("clock high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> ##190 !scl)
    else $error("clock low phase too short");

  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
  c_dev_ack: cover property (sda_d_oe && scl);
endmodule

// ===== tb/serial_register_access_slave_test.sv
module serial_register_access_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, r;
  logic pready, pslverr, irq, wr_stb, stb2, ack;
  logic rail = 1'b1;
  logic locked = 1'b0;
  logic [5:0] crit;
  logic [6:0] flg;
  logic [9:0] wcc;
  logic [4:0] wr_addr, idx, a0;
  logic [9:0] wr_data;
  logic [4:0] wr_addr2;
  logic [9:0] wr_data2;
  logic [9:0] mdl [32];
  logic [4:0] ri [4];
  logic [15:0] re [4];
  int n_mismatch = 0;
  int tests_run = 0;
  int n_wr = 0;
  int n_wr2 = 0;
  int seed = 32'hf6b3e165;

  srasl_if bus_if ();
  srasl_if bus2 ();

  always #12.5 clk = ~clk;

  srasl_ctrl u_srasl_ctrl (.clk(clk), .rst_b(rst_b), .bus(bus_if), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  srasl_target u_srasl_target (.clk(clk), .rst_b(rst_b), .bus(bus_if),
    .logic_rail_pin(1'b1), .locked_mode(locked), .crit_flags(crit),
    .thermal_warning_flag(flg[6]), .overtemp_flag(flg[5]), .sync_loss_flag(flg[4]),
    .gate_driver_fault_flag(flg[3]), .hard_overcurrent_flag(flg[2]),
    .supply_overvoltage_flag(flg[1]), .supply_undervoltage_flag(flg[0]),
    .write_cycle_count(wcc), .reg_wr_stb(wr_stb), .reg_wr_addr(wr_addr), .reg_wr_data(wr_data));
  srasl_target u_srasl_target_b (.clk(clk), .rst_b(rst_b), .bus(bus2),
    .logic_rail_pin(rail), .locked_mode(locked), .crit_flags(crit),
    .thermal_warning_flag(flg[6]), .overtemp_flag(flg[5]), .sync_loss_flag(flg[4]),
    .gate_driver_fault_flag(flg[3]), .hard_overcurrent_flag(flg[2]),
    .supply_overvoltage_flag(flg[1]), .supply_undervoltage_flag(flg[0]),
    .write_cycle_count(wcc), .reg_wr_stb(stb2), .reg_wr_addr(wr_addr2),
    .reg_wr_data(wr_data2));
  srasl_checker u_srasl_checker (.clk(clk), .rst_b(rst_b), .scl_m_oe(bus_if.scl_m_oe),
    .sda_m_oe(bus_if.sda_m_oe), .sda_d_oe(bus_if.sda_d_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  always @(posedge clk) begin
    if (wr_stb === 1'b1) n_wr++;
    if (stb2 === 1'b1) n_wr2++;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_mismatch++;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one link transfer, then poll for done and clear it
  task run(input logic [5:0] cmd, input logic en);
    int k;
    apb(1'b1, srasl_pkg::OFS_IRQ_EN, {31'h0, en});
    apb(1'b1, srasl_pkg::OFS_CMD, {26'h0, cmd});
    k = 0;
    do begin
      apb(1'b0, srasl_pkg::OFS_IRQ_STAT, 32'h0);
      k++;
    end while (q[0] !== 1'b1 && k < 20000);
    chk(q, 32'h1);
    chk({31'h0, irq}, {31'h0, en});
    apb(1'b0, srasl_pkg::OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, srasl_pkg::OFS_IRQ_CLR, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task bb_start;
    bus2.sda_m_oe <= 1'b0;
    repeat (4) @(posedge clk);
    bus2.scl_m_oe <= 1'b0;
    repeat (4) @(posedge clk);
    bus2.sda_m_oe <= 1'b1;
    repeat (4) @(posedge clk);
    bus2.scl_m_oe <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  // eight bits then a released slot; ack holds the slot's level
  task bb_byte(input logic [7:0] v);
    logic [8:0] w;
    w = {v, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      bus2.sda_m_oe <= !w[i];
      repeat (2) @(posedge clk);
      bus2.scl_m_oe <= 1'b0;
      repeat (3) @(posedge clk);
      ack = bus2.sda;
      @(posedge clk);
      bus2.scl_m_oe <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask

  initial begin
    #2_450_000;
    n_mismatch++;
    results;
  end

  initial begin
    bus2.scl_m_o = 1'b0;
    bus2.sda_m_o = 1'b0;
    bus2.scl_m_oe = 1'b0;
    bus2.sda_m_oe = 1'b0;
    r = $random(seed);
    crit = r[5:0];
    flg = r[12:6];
    wcc = r[25:16];
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, srasl_pkg::OFS_IRQ_EN, 32'h0);
    chk(q, {30'h0, srasl_pkg::IRQ_EN_RESET});
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    for (int j = 0; j < 2; j++) begin
      r = $random(seed);
      idx = j ? srasl_pkg::REG_PART_ID : {1'b0, r[19:16] % 4'hf};
      if (j == 0) a0 = idx;
      apb(1'b1, srasl_pkg::OFS_TXWORD, {16'h0, r[15:0]});
      run({1'b0, idx}, j[0]);
      chk(n_wr, j + 1);
      chk({27'h0, wr_addr}, {27'h0, idx});
      chk({22'h0, wr_data}, {22'h0, r[9:0]});
      mdl[idx] = r[9:0];
    end
    ri = '{a0, srasl_pkg::REG_EE_CTRL, srasl_pkg::REG_DIAG, srasl_pkg::REG_PART_ID};
    re = '{{crit, mdl[a0]}, {crit, wcc}, {crit, flg, 3'h0}, {crit, mdl[15]}};
    for (int j = 0; j < 4; j++) begin
      locked <= (j != 0);
      run({1'b1, ri[j]}, 1'b1);
      apb(1'b0, srasl_pkg::OFS_RXWORD, 32'h0);
      chk(q, {16'h0, re[j]});
    end
    chk(n_wr, 2);
    bb_start;
    bb_byte(8'h0a);
    chk({31'h0, ack}, 32'h0);
    bb_byte(8'h55);
    bb_start;
    bb_byte(8'h0a);
    bb_byte(8'h12);
    repeat (8) @(posedge clk);
    chk(n_wr2, 0);
    bb_start;
    bb_byte(8'h80);
    chk({31'h0, ack}, 32'h1);
    bb_byte(8'h00);
    chk({31'h0, ack}, 32'h1);
    // two words from index 5: the second lands at index 6
    bb_start;
    bb_byte(8'h0a);
    bb_byte(8'h01);
    bb_byte(8'h23);
    bb_byte(8'h02);
    bb_byte(8'h45);
    repeat (8) @(posedge clk);
    chk(n_wr2, 2);
    chk({27'h0, wr_addr2}, 32'h6);
    chk({22'h0, wr_data2}, 32'h245);
    rail <= 1'b0;
    repeat (10) @(posedge clk);
    bb_start;
    bb_byte(8'h0a);
    chk({31'h0, ack}, 32'h1);
    results;
  end
endmodule
